// File: rtl/ilc_pkg.sv
package ilc_pkg;

	// ==========================================================
	// register map (byte index on the 3-bit address port)
	localparam logic [2:0] ILC_LINE_CTRL_OFS = 3'h0;
	localparam logic [2:0] ILC_MODE_OFS      = 3'h1;
	localparam logic [2:0] ILC_XFER_CFG_OFS  = 3'h2;
	localparam logic [2:0] ILC_TX_DATA_OFS   = 3'h3;
	localparam logic [2:0] ILC_STATUS_OFS    = 3'h4;
	localparam logic [2:0] ILC_RX_DATA_OFS   = 3'h5;

	// ==========================================================
	// line control fields
	localparam int ILC_SDA_LEVEL_BIT  = 5;
	localparam int ILC_SDA_GUARD_BIT  = 4;
	localparam int ILC_SCL_MON_BIT    = 3;
	localparam int ILC_RSVD_HI_BIT    = 2;
	localparam int ILC_SOFT_RST_BIT   = 1;
	localparam int ILC_RSVD_LO_BIT    = 0;

	// ==========================================================
	// mode fields
	localparam int ILC_BIT_ORDER_BIT  = 7;
	localparam int ILC_WAIT_BIT       = 6;
	localparam logic [7:0] ILC_MODE_FIXED_ONES = 8'h38;

	// ==========================================================
	// transfer configuration and status fields
	localparam int ILC_CFG_MASTER_BIT = 0;
	localparam int ILC_CFG_SYNC_BIT   = 1;
	localparam int ILC_ST_BUSY_BIT    = 0;
	localparam int ILC_ST_ACK_BIT     = 1;

	// ==========================================================
	// reset values
	localparam logic       ILC_SDA_LEVEL_RST = 1'b1;
	localparam logic       ILC_BIT_ORDER_RST = 1'b0;
	localparam logic       ILC_WAIT_RST      = 1'b0;
	localparam logic [1:0] ILC_XFER_CFG_RST  = 2'h1;
	localparam logic [7:0] ILC_DATA_RST      = 8'h00;

	// ==========================================================
	// timing
	localparam int ILC_CLK_MHZ       = 50;
	localparam int ILC_HALF_BIT_NS   = 5000;
	localparam int ILC_HALF_BIT_CYC  = ILC_HALF_BIT_NS * ILC_CLK_MHZ / 1000;
	localparam int ILC_WAIT_CLOCKS   = 2;
	localparam logic [2:0] ILC_WAIT_HALVES = 3'(2 * ILC_WAIT_CLOCKS);
	localparam logic [3:0] ILC_LAST_DATA_IDX = 4'h7;
	localparam logic [3:0] ILC_ACK_IDX       = 4'h8;

	typedef enum logic [2:0]
	{
		ILC_IDLE = 3'h0,
		ILC_LOW  = 3'h1,
		ILC_HIGH = 3'h3,
		ILC_WAIT = 3'h2,
		ILC_DONE = 3'h6
	} ilc_state_t;

endpackage

// File: rtl/ilc_line_ctrl.sv
module ilc_line_ctrl
	import ilc_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       nrst,
	input  wire logic [2:0] addr,
	input  wire logic [7:0] wdata,
	input  wire logic       wr,
	input  wire logic       rd,
	output logic      [7:0] rdata,
	input  wire logic       sda_in,
	output logic            sda_out,
	output logic            sda_oe_n,
	output logic            scl_out,
	output logic            scl_oe_n
);

	// ==========================================================
	// reset release
	logic       rst_meta_ff;
	logic       rst_n_ff;

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			rst_meta_ff <= 1'b0;
			rst_n_ff    <= 1'b0;
		end
		else
		begin
			rst_meta_ff <= 1'b1;
			rst_n_ff    <= rst_meta_ff;
		end
	end

	// ==========================================================
	// declarations
	logic       sda_level_ff;
	logic       bit_order_ff;
	logic       wait_en_ff;
	logic [1:0] xfer_cfg_ff;
	logic [7:0] tx_data_ff;
	logic [7:0] rx_data_ff;
	logic       ack_ff;
	logic       soft_rst_ff;
	logic       start_ff;
	logic [7:0] rdata_ff;
	ilc_state_t state_ff;
	ilc_state_t nxt_state;
	logic [3:0] bit_idx_ff;
	logic [2:0] wait_cnt_ff;
	logic [8:0] div_cnt_ff;
	logic       tick;
	logic       eng_scl;
	logic       eng_sda;
	logic       busy;
	logic       sda_drv_level;
	logic       bus_fmt_master;

	localparam logic [8:0] DIV_LAST = 9'(ILC_HALF_BIT_CYC - 1);

	function automatic logic ilc_pick_bit(
		input logic [7:0] data,
		input logic [3:0] idx,
		input logic       lsb_first
	);
		logic [2:0] pos;
		pos = lsb_first ? idx[2:0] : 3'h7 - idx[2:0];
		return data[pos];
	endfunction

	assign busy           = (state_ff != ILC_IDLE);
	assign bus_fmt_master = xfer_cfg_ff[ILC_CFG_MASTER_BIT]
		& ~xfer_cfg_ff[ILC_CFG_SYNC_BIT];

	// ==========================================================
	// software registers; the soft reset never touches these
	wire wr_line = wr && (addr == ILC_LINE_CTRL_OFS);
	wire wr_mode = wr && (addr == ILC_MODE_OFS);

	always_ff @(posedge clk or negedge rst_n_ff)
	begin
		if (!rst_n_ff)
			sda_level_ff <= ILC_SDA_LEVEL_RST;
		else if (wr_line && !wdata[ILC_SDA_GUARD_BIT])
			sda_level_ff <= wdata[ILC_SDA_LEVEL_BIT];
	end

	// one-cycle pulse; reads back 0 outside that cycle
	always_ff @(posedge clk or negedge rst_n_ff)
	begin
		if (!rst_n_ff)
			soft_rst_ff <= 1'b0;
		else
			soft_rst_ff <= wr_line && wdata[ILC_SOFT_RST_BIT];
	end

	always_ff @(posedge clk or negedge rst_n_ff)
	begin
		if (!rst_n_ff)
		begin
			bit_order_ff <= ILC_BIT_ORDER_RST;
			wait_en_ff   <= ILC_WAIT_RST;
		end
		else if (wr_mode)
		begin
			bit_order_ff <= wdata[ILC_BIT_ORDER_BIT];
			wait_en_ff   <= wdata[ILC_WAIT_BIT];
		end
	end

	always_ff @(posedge clk or negedge rst_n_ff)
	begin
		if (!rst_n_ff)
			xfer_cfg_ff <= ILC_XFER_CFG_RST;
		else if (wr && (addr == ILC_XFER_CFG_OFS))
			xfer_cfg_ff <= wdata[1:0];
	end

	// a write while busy is dropped so the shifter stays consistent
	always_ff @(posedge clk or negedge rst_n_ff)
	begin
		if (!rst_n_ff)
		begin
			tx_data_ff <= ILC_DATA_RST;
			start_ff   <= 1'b0;
		end
		else
		begin
			start_ff <= 1'b0;
			if (wr && (addr == ILC_TX_DATA_OFS) && !busy
				&& xfer_cfg_ff[ILC_CFG_MASTER_BIT])
			begin
				tx_data_ff <= wdata;
				start_ff   <= 1'b1;
			end
		end
	end

	// ==========================================================
	// transfer clock divider: one enable pulse per half bit
	always_ff @(posedge clk or negedge rst_n_ff)
	begin
		if (!rst_n_ff)
			div_cnt_ff <= 9'h000;
		else if (soft_rst_ff || !busy || div_cnt_ff == DIV_LAST)
			div_cnt_ff <= 9'h000;
		else
			div_cnt_ff <= div_cnt_ff + 9'h001;
	end

	assign tick = busy && (div_cnt_ff == DIV_LAST);

	// ==========================================================
	// protocol engine
	always_comb
	begin
		nxt_state = state_ff;
		case (state_ff)
			ILC_IDLE:
			begin
				if (start_ff)
					nxt_state = ILC_LOW;
			end
			ILC_LOW:
			begin
				if (tick)
					nxt_state = ILC_HIGH;
			end
			ILC_HIGH:
			begin
				if (tick)
				begin
					if (bit_idx_ff == ILC_ACK_IDX)
						nxt_state = ILC_DONE;
					else if (bit_idx_ff == ILC_LAST_DATA_IDX)
					begin
						if (xfer_cfg_ff[ILC_CFG_SYNC_BIT])
							nxt_state = ILC_DONE;
						else if (bus_fmt_master && wait_en_ff)
							nxt_state = ILC_WAIT;
						else
							nxt_state = ILC_LOW;
					end
					else
						nxt_state = ILC_LOW;
				end
			end
			ILC_WAIT:
			begin
				if (tick && wait_cnt_ff == 3'h1)
					nxt_state = ILC_LOW;
			end
			ILC_DONE:
			begin
				nxt_state = ILC_IDLE;
			end
			default:
			begin
				nxt_state = ILC_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_n_ff)
	begin
		if (!rst_n_ff)
			state_ff <= ILC_IDLE;
		else if (soft_rst_ff)
			state_ff <= ILC_IDLE;
		else
			state_ff <= nxt_state;
	end

	always_ff @(posedge clk or negedge rst_n_ff)
	begin
		if (!rst_n_ff)
			bit_idx_ff <= 4'h0;
		else if (soft_rst_ff || state_ff == ILC_IDLE)
			bit_idx_ff <= 4'h0;
		else if (state_ff == ILC_HIGH && nxt_state != ILC_HIGH)
			bit_idx_ff <= bit_idx_ff + 4'h1;
	end

	// scl held low for the extra transfer clocks
	always_ff @(posedge clk or negedge rst_n_ff)
	begin
		if (!rst_n_ff)
			wait_cnt_ff <= 3'h0;
		else if (soft_rst_ff)
			wait_cnt_ff <= 3'h0;
		else if (nxt_state == ILC_WAIT && state_ff != ILC_WAIT)
			wait_cnt_ff <= ILC_WAIT_HALVES;
		else if (state_ff == ILC_WAIT && tick)
			wait_cnt_ff <= wait_cnt_ff - 3'h1;
	end

	// sample on the rising scl half; ack slot samples the peer
	always_ff @(posedge clk or negedge rst_n_ff)
	begin
		if (!rst_n_ff)
		begin
			rx_data_ff <= ILC_DATA_RST;
			ack_ff     <= 1'b0;
		end
		else if (state_ff == ILC_HIGH && tick)
		begin
			if (bit_idx_ff == ILC_ACK_IDX)
				ack_ff <= ~sda_in;
			else if (bit_order_ff)
				rx_data_ff <= {sda_in, rx_data_ff[7:1]};
			else
				rx_data_ff <= {rx_data_ff[6:0], sda_in};
		end
	end

	// ==========================================================
	// pin drive: open drain, oe_n low only when pulling low
	always_comb
	begin
		eng_scl = 1'b1;
		eng_sda = sda_level_ff;
		case (state_ff)
			ILC_LOW, ILC_WAIT:
			begin
				eng_scl = 1'b0;
				eng_sda = (bit_idx_ff == ILC_ACK_IDX) ? 1'b1
					: ilc_pick_bit(tx_data_ff, bit_idx_ff, bit_order_ff);
			end
			ILC_HIGH:
			begin
				eng_scl = 1'b1;
				eng_sda = (bit_idx_ff == ILC_ACK_IDX) ? 1'b1
					: ilc_pick_bit(tx_data_ff, bit_idx_ff, bit_order_ff);
			end
			default:
			begin
				eng_scl = 1'b1;
				eng_sda = sda_level_ff;
			end
		endcase
	end

	// a released data bit also lets the stored level through low
	assign sda_drv_level = busy ? (eng_sda & sda_level_ff) : sda_level_ff;

	always_ff @(posedge clk or negedge rst_n_ff)
	begin
		if (!rst_n_ff)
		begin
			sda_oe_n <= 1'b1;
			scl_oe_n <= 1'b1;
		end
		else
		begin
			sda_oe_n <= sda_drv_level;
			scl_oe_n <= eng_scl;
		end
	end

	assign sda_out = 1'b0;
	assign scl_out = 1'b0;

	// ==========================================================
	// read port: data valid in the cycle after the strobe
	always_ff @(posedge clk or negedge rst_n_ff)
	begin
		if (!rst_n_ff)
			rdata_ff <= 8'h00;
		else if (rd)
		begin
			case (addr)
				ILC_LINE_CTRL_OFS:
				begin
					rdata_ff <= 8'h00;
					rdata_ff[ILC_SDA_LEVEL_BIT] <= sda_oe_n;
					rdata_ff[ILC_SDA_GUARD_BIT] <= 1'b1;
					rdata_ff[ILC_SCL_MON_BIT]   <= scl_oe_n;
					rdata_ff[ILC_RSVD_HI_BIT]   <= 1'b1;
					rdata_ff[ILC_SOFT_RST_BIT]  <= soft_rst_ff;
					rdata_ff[ILC_RSVD_LO_BIT]   <= 1'b1;
				end
				ILC_MODE_OFS:
				begin
					rdata_ff <= ILC_MODE_FIXED_ONES;
					rdata_ff[ILC_BIT_ORDER_BIT] <= bit_order_ff;
					rdata_ff[ILC_WAIT_BIT]      <= wait_en_ff;
				end
				ILC_XFER_CFG_OFS:
					rdata_ff <= {6'h00, xfer_cfg_ff};
				ILC_TX_DATA_OFS:
					rdata_ff <= tx_data_ff;
				ILC_STATUS_OFS:
				begin
					rdata_ff <= 8'h00;
					rdata_ff[ILC_ST_BUSY_BIT] <= busy;
					rdata_ff[ILC_ST_ACK_BIT]  <= ack_ff;
				end
				ILC_RX_DATA_OFS:
					rdata_ff <= rx_data_ff;
				default:
					rdata_ff <= 8'h00;
			endcase
		end
		else
			rdata_ff <= 8'h00;
	end

	assign rdata = rdata_ff;

endmodule

// File: testbench/ilc_line_ctrl_props.sv
module ilc_line_ctrl_props
	import ilc_pkg::*;
(
	input wire logic       clk,
	input wire logic       nrst,
	input wire logic [2:0] addr,
	input wire logic [7:0] wdata,
	input wire logic       wr,
	input wire logic       rd,
	input wire logic [7:0] rdata,
	input wire logic       sda_out,
	input wire logic       sda_oe_n,
	input wire logic       scl_out,
	input wire logic       scl_oe_n
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [11:0] low_ff;
	logic        lc_rd;
	logic        lc_wr;
	assign lc_rd = rd && addr == ILC_LINE_CTRL_OFS;
	assign lc_wr = wr && addr == ILC_LINE_CTRL_OFS;
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	// ==========================================================
	// scl low run length, the wait is the longest legal one
	always_ff @(posedge clk or negedge nrst)
		if (!nrst)
			low_ff <= 12'h000;
		else
			low_ff <= scl_oe_n ? 12'h000 : low_ff + 12'h001;
	chk_guard_reads_one:
		assert property (lc_rd |=> rdata[ILC_SDA_GUARD_BIT])
		else $error("guard bit read as 0");
	chk_rsvd_read_one:
		assert property (lc_rd |=> rdata[2] && rdata[0])
		else $error("reserved bit read as 0");
	chk_scl_mon_level:
		assert property (lc_rd |=> rdata[3] == $past(scl_oe_n))
		else $error("scl monitor differs from pin");
	chk_sda_read_level:
		assert property (lc_rd |=> rdata[5] == $past(sda_oe_n))
		else $error("sda level read differs from pin");
	chk_rdata_one_cycle:
		assert property (!rd |=> rdata == 8'h00)
		else $error("read data outside its cycle");
	chk_soft_rst_idle:
		assert property (lc_wr && wdata[ILC_SOFT_RST_BIT] |=> ##2 scl_oe_n)
		else $error("scl held after soft reset");
	chk_sda_drive_low:
		assert property (lc_wr && wdata[5:4] == 2'b00 |=> ##1 !sda_oe_n)
		else $error("sda not pulled low");
	chk_wait_bound:
		assert property (low_ff <= 12'h4e2)
		else $error("scl low too long");
	chk_open_drain:
		assert property (sda_out == 1'b0 && scl_out == 1'b0)
		else $error("open drain output driven high");
endmodule

bind ilc_line_ctrl ilc_line_ctrl_props chk_u (.clk(clk), .nrst(nrst),
	.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
	.sda_out(sda_out), .sda_oe_n(sda_oe_n), .scl_out(scl_out),
	.scl_oe_n(scl_oe_n));

// File: testbench/ilc_bus_peer.sv
module ilc_bus_peer
(
	input  wire logic       clk,
	input  wire logic       clr,
	input  wire logic       ack_en,
	input  wire logic       scl,
	input  wire logic       sda,
	output logic            sda_rel,
	output logic [7:0]      rx_byte
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] cnt_ff;
	logic       scl_q;
	// ==========================================================
	// samples on scl rise, acks in the ninth low phase
	always_ff @(posedge clk)
	begin
		scl_q <= scl;
		if (clr)
		begin
			cnt_ff  <= 4'h0;
			sda_rel <= 1'b1;
		end
		else if (scl && !scl_q && cnt_ff < 4'h9)
		begin
			cnt_ff <= cnt_ff + 4'h1;
			if (cnt_ff < 4'h8)
				rx_byte <= {rx_byte[6:0], sda};
		end
		else if (!scl && scl_q)
			sda_rel <= !(ack_en && cnt_ff == 4'h8);
	end
endmodule

// File: testbench/ilc_line_ctrl_tb_top.sv
module ilc_line_ctrl_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk = 1'b0;
	logic        nrst = 1'b0;
	logic [2:0]  addr = 3'h0;
	logic [7:0]  wdata = 8'h00;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic        clr = 1'b1;
	logic        ack_en = 1'b0;
	logic [7:0]  rdata;
	logic        sda_out;
	logic        sda_oe_n;
	logic        scl_out;
	logic        scl_oe_n;
	logic        sda_rel;
	logic [7:0]  rx_byte;
	logic [31:0] seed = 32'h00f1e0e7;
	logic [7:0]  r;
	logic        lvl = 1'b1;
	int          fail_count = 0;
	int          n_checks = 0;
	int          low_run = 0;
	int          max_low = 0;
	int          cyc = 0;
	wire         sda = sda_oe_n & sda_rel;

	ilc_line_ctrl dut_u (.clk(clk), .nrst(nrst), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .sda_in(sda),
		.sda_out(sda_out), .sda_oe_n(sda_oe_n), .scl_out(scl_out),
		.scl_oe_n(scl_oe_n));
	ilc_bus_peer peer_u (.clk(clk), .clr(clr), .ack_en(ack_en),
		.scl(scl_oe_n), .sda(sda), .sda_rel(sda_rel), .rx_byte(rx_byte));

	always #10 clk = ~clk;
	always @(posedge clk)
	begin
		low_run = scl_oe_n ? 0 : low_run + 1;
		if (low_run > max_low)
			max_low = low_run;
		cyc++;
		if (cyc == 60000)
		begin
			fail_count++;
			tally_and_finish();
		end
	end

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	function automatic logic [7:0] lc_exp(input logic l);
		return {2'b00, l, 5'b11101};
	endfunction
	function automatic logic [7:0] rev8(input logic [7:0] v);
		logic [7:0] o;
		for (int i = 0; i < 8; i++)
			o[i] = v[7 - i];
		return o;
	endfunction

	task automatic chk(input string nm, input logic [15:0] seen,
		input logic [15:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
		@(posedge clk);
	endtask
	// bus format and sync transfers both take their bit order from mode bit 7
	task automatic xfer(input logic [7:0] cfg, input logic [7:0] mode,
		input logic ack, input int low_exp);
		logic [7:0] d;
		seed = xs(seed);
		d = seed[7:0];
		wr_reg(3'h2, cfg);
		wr_reg(3'h1, mode);
		ack_en <= ack;
		clr <= 1'b1;
		@(posedge clk);
		clr <= 1'b0;
		max_low = 0;
		wr_reg(3'h3, d);
		for (int i = 0; i < 200; i++)
		begin
			rd_reg(3'h4, r);
			if (!r[0])
				break;
			repeat (50) @(posedge clk);
		end
		chk("rx byte", 16'(rx_byte), 16'(mode[7] ? rev8(d) : d));
		chk("scl low", 16'(max_low), 16'(low_exp));
		chk("ack", 16'(r[1]), 16'(ack));
		rd_reg(3'h5, r);
		chk("rx reg", 16'(r), 16'(d));
		$display("transfer cfg %h mode %h done", cfg, mode);
	endtask

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	initial
	begin
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		repeat (3) @(posedge clk);
		rd_reg(3'h0, r);
		chk("line ctrl rst", 16'(r), 16'(lc_exp(1'b1)));
		rd_reg(3'h1, r);
		chk("mode rst", 16'(r), 16'h0038);
		rd_reg(3'h6, r);
		chk("unmapped", 16'(r), 16'h0000);
		$display("reset values done");
		for (int i = 0; i < 24; i++)
		begin
			seed = xs(seed);
			wr_reg(3'h0, seed[7:0] & 8'hfd);
			if (!seed[4])
				lvl = seed[5];
			rd_reg(3'h0, r);
			chk("line ctrl", 16'(r), 16'(lc_exp(lvl)));
			chk("sda pin", 16'(sda_oe_n), 16'(lvl));
			wr_reg(3'h1, seed[15:8]);
			rd_reg(3'h1, r);
			chk("mode", 16'(r), 16'({seed[15:14], 6'h38}));
		end
		$display("random register access done");
		wr_reg(3'h0, 8'h20);
		xfer(8'h01, 8'h00, 1'b1, 250);
		xfer(8'h01, 8'h40, 1'b0, 1250);
		xfer(8'h03, 8'hc0, 1'b0, 250);
		wr_reg(3'h2, 8'h00);
		wr_reg(3'h3, 8'h5a);
		rd_reg(3'h4, r);
		chk("slave busy", 16'(r[0]), 16'h0000);
		wr_reg(3'h2, 8'h01);
		wr_reg(3'h1, 8'h40);
		wr_reg(3'h3, 8'ha5);
		repeat (600) @(posedge clk);
		rd_reg(3'h0, r);
		chk("scl mon low", 16'(r[3]), 16'h0000);
		wr_reg(3'h0, 8'h12);
		rd_reg(3'h4, r);
		chk("busy after soft rst", 16'(r[0]), 16'h0000);
		rd_reg(3'h0, r);
		chk("kept line ctrl", 16'(r), 16'(lc_exp(1'b1)));
		rd_reg(3'h1, r);
		chk("kept mode", 16'(r), 16'h0078);
		$display("soft reset done");
		tally_and_finish();
	end
endmodule
